// File: design/vwi_pkg.sv
// Behaviour
// - 24-bit address, 32-bit data, three strobes
// - three exclusive areas, two configured independently, io fixed at 32 bits
// - control register changes apply without reset
// - width pin high: two halves, low: one word
// - assemble two program halves into one word
// - strobe set active only inside its range
// - physical width field: 8, 16 or 32
// - data width field independent of physical width
// - two lane enables plus two dual-purpose pins
// - 8-bit: both address pins, lane0 selects
// - 16-bit: addr1 pin, lanes 0 and 1
// - 32-bit: all four pins are lane enables
// - 32-bit words on 16-bit memory: two accesses
// - no program fetch from 8-bit memory
// - io strobe: single pin, 32-bit only
// - io strobe uses slower access timing
package vwi_pkg;
  // ----------------------------------------------------------
  // widths
  // ----------------------------------------------------------
  localparam int ADDR_W = 24;
  localparam int DATA_W = 32;
  // width encodings shared by both width fields
  localparam logic [1:0] W8 = 2'h0;
  localparam logic [1:0] W16 = 2'h1;
  localparam logic [1:0] W32 = 2'h2;
  // ----------------------------------------------------------
  // register map (byte offsets)
  // ----------------------------------------------------------
  localparam logic [7:0] REG_CTRL0 = 8'h00;
  localparam logic [7:0] REG_CTRL1 = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  // control fields: physical width [1:0], data width [3:2]
  localparam int PHYS_LSB = 0;
  localparam int DATA_LSB = 2;
  localparam int CTRL_W = 4;
  localparam logic [3:0] CTRL_RST = 4'ha;
  // status bits
  localparam int STAT_BUSY = 0;
  localparam int STAT_PROGRAM_WIDTH_SELECT = 1;
  // ----------------------------------------------------------
  // address ranges
  // ----------------------------------------------------------
  localparam logic [7:0] IO_PAGE = 8'h81;
  localparam int SET1_BIT = 23;
  // targets
  localparam logic [1:0] T_SET0 = 2'h0;
  localparam logic [1:0] T_SET1 = 2'h1;
  localparam logic [1:0] T_IO = 2'h2;
  // ----------------------------------------------------------
  // timing
  // ----------------------------------------------------------
  localparam int CLK_NS = 10;
  localparam int MEM_STROBE_NS = 50;
  localparam int IO_STROBE_NS = 100;
  localparam int MEM_STROBE_CYC = (MEM_STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int IO_STROBE_CYC = (IO_STROBE_NS + CLK_NS - 1) / CLK_NS;
  // ----------------------------------------------------------
  // types and helpers
  // ----------------------------------------------------------
  typedef enum logic [2:0] {
    S_IDLE, S_SETUP, S_STROBE, S_HOLD, S_DONE
  } vwi_state_type;
  // bytes per width code; reserved code treated as 32 bits
  function automatic logic [2:0] vwi_bytes(input logic [1:0] enc);
    vwi_bytes = (enc == W8) ? 3'h1 : (enc == W16) ? 3'h2 : 3'h4;
  endfunction : vwi_bytes
  // clamp reserved width code to 32 bits
  function automatic logic [1:0] vwi_norm(input logic [1:0] enc);
    vwi_norm = (enc > W32) ? W32 : enc;
  endfunction : vwi_norm
endpackage : vwi_pkg

// File: design/vwi_sync3.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// three-stage pin synchroniser; output moves once stages agree
// ------------------------------------------------------------
module vwi_sync3 #(
  parameter int W = 1
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [W-1:0] pin,
  output logic [W-1:0] q
);
  logic [W-1:0] s1; // metastable stage, read only by s2
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  // shift chain and agreement filter
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      q <= '0;
    end
    else
    begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
      // a glitch lasting one cycle never reaches q
      if (s2 == s3)
      begin
        q <= s3;
      end
    end
  end
endmodule : vwi_sync3
`default_nettype wire

// File: design/vwi_lane_map.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// maps physical width, beat size and low address onto the
// four pins of a strobe set (pin [2]=lane2/addr2, [3]=lane3/addr1)
// ------------------------------------------------------------
module vwi_lane_map (
  input wire logic [1:0] phys_enc,
  input wire logic [1:0] beat_enc,
  input wire logic [1:0] low,
  output logic [3:0] pins,
  output logic [1:0] lane_off
);
  logic [2:0] pbytes; // bytes of physical width
  logic [2:0] bbytes; // bytes moved this beat
  logic [3:0] en_n; // active-low enable per byte lane
  assign pbytes = vwi_pkg::vwi_bytes(phys_enc);
  assign bbytes = vwi_pkg::vwi_bytes(beat_enc);
  // lane offset inside the physical word
  assign lane_off = (phys_enc == vwi_pkg::W8) ? 2'h0 :
                    (phys_enc == vwi_pkg::W16) ? {1'b0, low[0]} : low;
  // enable only lanes covered by the addressed bytes
  genvar i;
  generate
    for (i = 0; i < 4; i++)
    begin : g_lane
      assign en_n[i] = !((3'(i) >= {1'b0, lane_off}) &&
                         (3'(i) < ({1'b0, lane_off} + bbytes)) &&
                         (3'(i) < pbytes));
    end
  endgenerate
  // pin function follows physical width
  assign pins = (phys_enc == vwi_pkg::W8) ?
                  {low[1], low[0], 1'b1, en_n[0]} :
                (phys_enc == vwi_pkg::W16) ?
                  {low[1], 1'b1, en_n[1], en_n[0]} :
                  en_n;
endmodule : vwi_lane_map
`default_nettype wire

// File: design/vwi_ext_mem_if.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// variable-width external memory interface
// ------------------------------------------------------------
module vwi_ext_mem_if #(
  parameter int MEM_CYC = vwi_pkg::MEM_STROBE_CYC,
  parameter int IO_CYC = vwi_pkg::IO_STROBE_CYC
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  // wishbone register slave
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [7:0] wb_adr,
  input wire logic [3:0] wb_sel,
  input wire logic [31:0] wb_dat_w,
  output logic [31:0] wb_dat_r,
  output logic wb_ack,
  // cpu / dma request port
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic req_prog,
  input wire logic [23:0] req_addr,
  input wire logic [31:0] req_wdata,
  output logic resp_valid,
  output logic [31:0] resp_rdata,
  // external pins
  input wire logic program_width_select,
  output logic [23:0] ext_addr,
  output logic [31:0] ext_data_o,
  input wire logic [31:0] ext_data_i,
  output logic ext_data_oe,
  output logic ext_write_n,
  output logic s0_lane0_enable_n,
  output logic s0_lane1_enable_n,
  output logic s0_lane2_enable_or_addr2,
  output logic s0_lane3_enable_or_addr1,
  output logic s1_lane0_enable_n,
  output logic s1_lane1_enable_n,
  output logic s1_lane2_enable_or_addr2,
  output logic s1_lane3_enable_or_addr1,
  output logic io_strobe_n
);
  // ----------------------------------------------------------
  // state
  // ----------------------------------------------------------
  vwi_pkg::vwi_state_type state;
  logic [3:0] ctrl0; // strobe set zero widths
  logic [3:0] ctrl1; // strobe set one widths
  logic [1:0] tgt_q; // captured target
  logic wr_q; // captured direction
  logic [23:0] addr_q; // captured address
  logic [31:0] wdata_q; // captured write data
  logic [1:0] pw_q; // physical width of this access
  logic [1:0] dw_q; // data width of this access
  logic [1:0] beat_q; // beat index within the access
  logic [3:0] cnt_q; // strobe cycle counter
  logic [31:0] acc_q; // read data being assembled
  logic [3:0] s0_pins; // set zero pin flops
  logic [3:0] s1_pins; // set one pin flops
  // ----------------------------------------------------------
  // synchronised pin inputs
  // ----------------------------------------------------------
  logic program_width_select_s; // program width pin, synchronised
  logic [31:0] din_s; // data bus, synchronised
  vwi_sync3 #(.W(1)) u_program_width_select (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .pin(program_width_select),
    .q(program_width_select_s)
  );
  vwi_sync3 #(.W(32)) u_din (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .pin(ext_data_i),
    .q(din_s)
  );
  // ----------------------------------------------------------
  // request decode
  // ----------------------------------------------------------
  wire logic take = req_valid && req_ready;
  // io page lies inside set one's range and takes priority, so one area is chosen
  wire logic [1:0] tgt_in =
    (req_addr[23:16] == vwi_pkg::IO_PAGE) ? vwi_pkg::T_IO :
    req_addr[vwi_pkg::SET1_BIT] ? vwi_pkg::T_SET1 : vwi_pkg::T_SET0;
  wire logic [3:0] cfg_in =
    (tgt_in == vwi_pkg::T_SET1) ? ctrl1 : ctrl0;
  wire logic [1:0] cfg_pw =
    vwi_pkg::vwi_norm(cfg_in[vwi_pkg::PHYS_LSB +: 2]);
  wire logic [1:0] cfg_dw =
    vwi_pkg::vwi_norm(cfg_in[vwi_pkg::DATA_LSB +: 2]);
  // program fetch width comes from the pin, never 8 bits
  wire logic [1:0] prog_pw =
    program_width_select_s ? vwi_pkg::W16 : vwi_pkg::W32;
  // io is always a full word on a full-width device
  wire logic is_io = (tgt_in == vwi_pkg::T_IO);
  wire logic [1:0] pw_in =
    is_io ? vwi_pkg::W32 :
    req_prog ? prog_pw : cfg_pw;
  wire logic [1:0] dw_in =
    (is_io || req_prog) ? vwi_pkg::W32 : cfg_dw;
  // ----------------------------------------------------------
  // beat arithmetic
  // ----------------------------------------------------------
  // bytes per beat are the smaller of data and physical width
  wire logic [1:0] bw = (dw_q < pw_q) ? dw_q : pw_q;
  // wider data than memory splits into several beats
  wire logic [1:0] last_beat =
    2'((3'h1 << (dw_q - bw)) - 3'h1);
  // byte offset of this beat inside the data word
  wire logic [1:0] beat_off = 2'({2'h0, beat_q} << bw);
  // each data location owns its own byte address
  wire logic [25:0] base = 26'({2'h0, addr_q} << dw_q);
  wire logic [25:0] pb = base + {24'h00_0000, beat_off};
  // ----------------------------------------------------------
  // lane mapping
  // ----------------------------------------------------------
  logic [3:0] map_pins;
  logic [1:0] lane_off;
  vwi_lane_map u_map (
    .phys_enc(pw_q),
    .beat_enc(bw),
    .low(pb[1:0]),
    .pins(map_pins),
    .lane_off(lane_off)
  );
  // write data of this beat moved onto its lanes
  wire logic [31:0] wr_lanes =
    (wdata_q >> {beat_off, 3'h0}) << {lane_off, 3'h0};
  // read data of this beat pulled off its lanes
  wire logic [31:0] rd_mask =
    ~(32'hffff_ffff << {vwi_pkg::vwi_bytes(bw), 3'h0});
  wire logic [31:0] rd_chunk =
    ((din_s >> {lane_off, 3'h0}) & rd_mask) << {beat_off, 3'h0};
  // slower strobe for peripherals on the io range
  wire logic [3:0] strobe_len =
    (tgt_q == vwi_pkg::T_IO) ? 4'(IO_CYC - 1) : 4'(MEM_CYC - 1);
  // ----------------------------------------------------------
  // access sequencer
  // ----------------------------------------------------------
  // setup drives address, data and the lanes in one step, strobe closes the lanes,
  // hold drops the data drive before the next beat or the answer
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= vwi_pkg::S_IDLE;
      req_ready <= 1'b0;
      resp_valid <= 1'b0;
      resp_rdata <= 32'h0000_0000;
      tgt_q <= vwi_pkg::T_SET0;
      wr_q <= 1'b0;
      addr_q <= 24'h00_0000;
      wdata_q <= 32'h0000_0000;
      pw_q <= vwi_pkg::W32;
      dw_q <= vwi_pkg::W32;
      beat_q <= 2'h0;
      cnt_q <= 4'h0;
      acc_q <= 32'h0000_0000;
      ext_addr <= 24'h00_0000;
      ext_data_o <= 32'h0000_0000;
      ext_data_oe <= 1'b0;
      ext_write_n <= 1'b1;
      s0_pins <= 4'hf;
      s1_pins <= 4'hf;
      io_strobe_n <= 1'b1;
    end
    else
    begin
      resp_valid <= 1'b0;
      case (state)
        vwi_pkg::S_IDLE:
        begin
          req_ready <= 1'b1;
          if (take)
          begin
            // widths latched per access, so register writes
            // take hold on the next access
            req_ready <= 1'b0;
            tgt_q <= tgt_in;
            wr_q <= req_write;
            addr_q <= req_addr;
            wdata_q <= req_wdata;
            pw_q <= pw_in;
            dw_q <= dw_in;
            beat_q <= 2'h0;
            acc_q <= 32'h0000_0000;
            state <= vwi_pkg::S_SETUP;
          end
        end
        vwi_pkg::S_SETUP:
        begin
          // full 24-bit word address, 32-bit data bus
          ext_addr <= pb[25:2];
          ext_data_o <= wr_lanes;
          ext_data_oe <= wr_q;
          ext_write_n <= !wr_q;
          cnt_q <= strobe_len;
          state <= vwi_pkg::S_STROBE;
          // only the targeted set leaves idle
          if (tgt_q == vwi_pkg::T_SET0)
          begin
            s0_pins <= map_pins;
          end
          else if (tgt_q == vwi_pkg::T_SET1)
          begin
            s1_pins <= map_pins;
          end
          else
          begin
            io_strobe_n <= 1'b0;
          end
        end
        vwi_pkg::S_STROBE:
        begin
          if (cnt_q == 4'h0)
          begin
            // halves land at their offset in the word
            acc_q <= acc_q | rd_chunk;
            s0_pins <= 4'hf;
            s1_pins <= 4'hf;
            io_strobe_n <= 1'b1;
            state <= vwi_pkg::S_HOLD;
          end
          else
          begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        vwi_pkg::S_HOLD:
        begin
          ext_data_oe <= 1'b0;
          ext_write_n <= 1'b1;
          if (beat_q == last_beat)
          begin
            state <= vwi_pkg::S_DONE;
          end
          else
          begin
            beat_q <= beat_q + 2'h1;
            state <= vwi_pkg::S_SETUP;
          end
        end
        vwi_pkg::S_DONE:
        begin
          resp_valid <= 1'b1;
          resp_rdata <= acc_q;
          req_ready <= 1'b1;
          state <= vwi_pkg::S_IDLE;
        end
        default:
        begin
          state <= vwi_pkg::S_IDLE;
        end
      endcase
    end
  end
  // ----------------------------------------------------------
  // pin outputs
  // ----------------------------------------------------------
  assign s0_lane0_enable_n = s0_pins[0];
  assign s0_lane1_enable_n = s0_pins[1];
  assign s0_lane2_enable_or_addr2 = s0_pins[2];
  assign s0_lane3_enable_or_addr1 = s0_pins[3];
  assign s1_lane0_enable_n = s1_pins[0];
  assign s1_lane1_enable_n = s1_pins[1];
  assign s1_lane2_enable_or_addr2 = s1_pins[2];
  assign s1_lane3_enable_or_addr1 = s1_pins[3];
  // ----------------------------------------------------------
  // wishbone register slave
  // ----------------------------------------------------------
  wire logic wb_go = wb_cyc && wb_stb && !wb_ack;
  wire logic hit_c0 = (wb_adr == vwi_pkg::REG_CTRL0);
  wire logic hit_c1 = (wb_adr == vwi_pkg::REG_CTRL1);
  wire logic hit_st = (wb_adr == vwi_pkg::REG_STATUS);
  // status shows live sequencer and pin state
  wire logic [31:0] status_word =
    {30'h0000_0000, program_width_select_s, state != vwi_pkg::S_IDLE};
  // unmapped offsets read zero and ignore writes
  wire logic [31:0] rd_word =
    hit_c0 ? {28'h000_0000, ctrl0} :
    hit_c1 ? {28'h000_0000, ctrl1} :
    hit_st ? status_word : 32'h0000_0000;
  // control byte lives in lane zero
  wire logic wr_c0 = wb_go && wb_we && wb_sel[0] && hit_c0;
  wire logic wr_c1 = wb_go && wb_we && wb_sel[0] && hit_c1;
  // one ack per request, dropped the cycle after
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wb_ack <= 1'b0;
      wb_dat_r <= 32'h0000_0000;
      ctrl0 <= vwi_pkg::CTRL_RST;
      ctrl1 <= vwi_pkg::CTRL_RST;
    end
    else
    begin
      wb_ack <= wb_go;
      wb_dat_r <= wb_go ? rd_word : 32'h0000_0000;
      // each set configured on its own
      if (wr_c0)
      begin
        ctrl0 <= wb_dat_w[vwi_pkg::CTRL_W-1:0];
      end
      if (wr_c1)
      begin
        ctrl1 <= wb_dat_w[vwi_pkg::CTRL_W-1:0];
      end
    end
  end
endmodule : vwi_ext_mem_if
`default_nettype wire

// File: test/vwi_ext_mem_if_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ----------
// port rules
// ----------
module vwi_ext_mem_if_chk #(
  parameter int MEM_CYC = 5,
  parameter int IO_CYC = 10
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_ack,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic resp_valid,
  input wire logic ext_write_n,
  input wire logic ext_data_oe,
  input wire logic s0_lane0_enable_n,
  input wire logic s0_lane1_enable_n,
  input wire logic s0_lane2_enable_or_addr2,
  input wire logic s0_lane3_enable_or_addr1,
  input wire logic s1_lane0_enable_n,
  input wire logic s1_lane1_enable_n,
  input wire logic s1_lane2_enable_or_addr2,
  input wire logic s1_lane3_enable_or_addr1,
  input wire logic io_strobe_n
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // a set is busy when any of its pins leaves the idle high level
  logic on0;
  logic on1;
  logic [7:0] cm; // cycles a memory set has been busy
  logic [7:0] ci; // cycles the io strobe has been low
  assign on0 = ~&{s0_lane0_enable_n, s0_lane1_enable_n,
    s0_lane2_enable_or_addr2, s0_lane3_enable_or_addr1};
  assign on1 = ~&{s1_lane0_enable_n, s1_lane1_enable_n,
    s1_lane2_enable_or_addr2, s1_lane3_enable_or_addr1};
  // strobe length counters, cleared whenever the strobe is idle
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cm <= 8'h00;
      ci <= 8'h00;
    end
    else
    begin
      cm <= (on0 || on1) ? cm + 8'h01 : 8'h00;
      ci <= !io_strobe_n ? ci + 8'h01 : 8'h00;
    end
  end
  property p_wb_ack;
    wb_cyc && wb_stb && !wb_ack |=> wb_ack;
  endproperty
  a_wb_ack: assert property (p_wb_ack) else $error("late ack");
  property p_wb_pulse;
    wb_ack |=> !wb_ack;
  endproperty
  a_wb_pulse: assert property (p_wb_pulse) else $error("ack on");
  property p_excl;
    $onehot0({on0, on1, !io_strobe_n});
  endproperty
  a_excl: assert property (p_excl) else $error("two areas on");
  property p_io_len;
    $rose(io_strobe_n) |-> ci == IO_CYC;
  endproperty
  a_io_len: assert property (p_io_len) else $error("io len");
  property p_mem_len;
    $fell(on0 || on1) |-> cm == MEM_CYC;
  endproperty
  a_mem_len: assert property (p_mem_len) else $error("mem len");
  property p_take;
    req_valid && req_ready |=> !req_ready;
  endproperty
  a_take: assert property (p_take) else $error("ready held");
  property p_resp;
    resp_valid |=> !resp_valid;
  endproperty
  a_resp: assert property (p_resp) else $error("long resp");
  property p_busy;
    on0 || on1 || !io_strobe_n |-> !req_ready;
  endproperty
  a_busy: assert property (p_busy) else $error("idle strobe");
  property p_wr_oe;
    !ext_write_n |-> ext_data_oe;
  endproperty
  a_wr_oe: assert property (p_wr_oe) else $error("bus undriven");
endmodule : vwi_ext_mem_if_chk
`default_nettype wire

// File: test/vwi_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// -----------------------------------------
// external memory and io device, one array
// -----------------------------------------
module vwi_mem_model (
  input wire logic ref_clk,
  input wire logic [23:0] ext_addr,
  input wire logic [31:0] ext_data_o,
  input wire logic ext_write_n,
  input wire logic s0_lane0_enable_n,
  input wire logic s0_lane1_enable_n,
  input wire logic s0_lane2_enable_or_addr2,
  input wire logic s0_lane3_enable_or_addr1,
  input wire logic s1_lane0_enable_n,
  input wire logic s1_lane1_enable_n,
  input wire logic s1_lane2_enable_or_addr2,
  input wire logic s1_lane3_enable_or_addr1,
  input wire logic io_strobe_n,
  input wire logic [1:0] phys0,
  input wire logic [1:0] phys1,
  output logic [31:0] ext_data_i
);
  // cleared so lanes never written read as zero, not unknown;
  // an unknown lane would stall the design's agreement filter
  logic [31:0] mem [1024] = '{default: 32'h0000_0000};
  logic [31:0] last = 32'h0000_0000; // last driven, inverted when idle
  wire logic [3:0] p0 = {s0_lane3_enable_or_addr1,
    s0_lane2_enable_or_addr2, s0_lane1_enable_n, s0_lane0_enable_n};
  wire logic [3:0] p1 = {s1_lane3_enable_or_addr1,
    s1_lane2_enable_or_addr2, s1_lane1_enable_n, s1_lane0_enable_n};
  wire logic on1 = ~&p1;
  wire logic onio = !io_strobe_n;
  wire logic act = ~&p0 | on1 | onio;
  wire logic [3:0] pin = on1 ? p1 : p0;
  wire logic [1:0] ph = on1 ? phys1 : phys0;
  // narrow memories take the low byte address from the dual pins
  wire logic [1:0] idx = onio ? 2'h0 : (ph == 2'h0) ? pin[3:2] :
    (ph == 2'h1) ? {pin[3], 1'h0} : 2'h0;
  wire logic [9:0] key = {onio, on1, ext_addr[5:0], idx};
  // only a wide memory honours the lane enables
  wire logic [3:0] be = (onio || ph != 2'h2) ? 4'hf : ~pin;
  // store selected lanes; idle bus shows no stale value
  always @(posedge ref_clk)
  begin
    for (int b = 0; b < 4; b++)
      if (act && !ext_write_n && be[b])
        mem[key][8*b +: 8] <= ext_data_o[8*b +: 8];
    if (act)
      last <= ext_data_i;
  end
  assign ext_data_i = (act && ext_write_n) ? mem[key] : ~last;
endmodule : vwi_mem_model
`default_nettype wire

// File: test/test_variable_width_ext_mem_interface.sv
`timescale 1ns/1ps
`default_nettype none
// -------------------------------
// register and access sequences
// -------------------------------
module test_variable_width_ext_mem_interface;
  logic ref_clk = 1'h0;
  logic rst_n = 1'h0;
  logic wb_cyc = 1'h0;
  logic wb_stb = 1'h0;
  logic wb_we = 1'h0;
  logic [7:0] wb_adr = 8'h00;
  logic [3:0] wb_sel = 4'hf;
  logic [31:0] wb_dat_w = 32'h0000_0000;
  logic [31:0] wb_dat_r;
  logic wb_ack;
  logic req_valid = 1'h0;
  logic req_ready;
  logic req_write = 1'h0;
  logic req_prog = 1'h0;
  logic [23:0] req_addr = 24'h00_0000;
  logic [31:0] req_wdata = 32'h0000_0000;
  logic resp_valid;
  logic [31:0] resp_rdata;
  logic program_width_select = 1'h0;
  logic [23:0] ext_addr;
  logic [31:0] ext_data_o;
  logic [31:0] ext_data_i;
  logic ext_data_oe;
  logic ext_write_n;
  logic s0_lane0_enable_n;
  logic s0_lane1_enable_n;
  logic s0_lane2_enable_or_addr2;
  logic s0_lane3_enable_or_addr1;
  logic s1_lane0_enable_n;
  logic s1_lane1_enable_n;
  logic s1_lane2_enable_or_addr2;
  logic s1_lane3_enable_or_addr1;
  logic io_strobe_n;
  logic [1:0] phys0 = 2'h2; // model's view of each set's width
  logic [1:0] phys1 = 2'h2;
  logic [1:0] tgt = 2'h0; // area under test: 0, 1 or io
  int n_fail = 0;
  int num_checks = 0;
  int cyc = 0;
  int beats = 0;
  int eb;
  logic [3:0] pins1; // pins seen in the first beat
  logic [3:0] pins_sel;
  logic on;
  logic on_q = 1'h0;
  logic [15:0] r;
  logic [23:0] a;
  logic [31:0] d;
  logic [31:0] q;
  // row: phys, data, address, first-beat pins, pins that matter
  logic [15:0] tab [8] = '{16'ha30f, 16'h85df, 16'h933f, 16'h620b,
    16'h479b, 16'h210d, 16'h138d, 16'h028d};
  vwi_ext_mem_if dut (.*);
  vwi_mem_model u_mem (.*);
  always #5 ref_clk = ~ref_clk;
  // beat counter on the area under test
  assign pins_sel = tgt[0] ? {s1_lane3_enable_or_addr1,
    s1_lane2_enable_or_addr2, s1_lane1_enable_n, s1_lane0_enable_n} :
    {s0_lane3_enable_or_addr1, s0_lane2_enable_or_addr2,
    s0_lane1_enable_n, s0_lane0_enable_n};
  assign on = tgt[1] ? !io_strobe_n : ~&pins_sel;
  always @(posedge ref_clk)
  begin
    on_q <= on;
    if (on && !on_q)
    begin
      beats = beats + 1;
      if (beats == 1)
        pins1 = pins_sel;
    end
  end
  // hang guard, far beyond the planned run
  always @(posedge ref_clk)
  begin
    cyc = cyc + 1;
    if (cyc == 20000)
    begin
      n_fail = n_fail + 1;
      report_and_stop();
    end
  end
  task report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : report_and_stop
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks = num_checks + 1;
    if (seen !== exp)
    begin
      n_fail = n_fail + 1;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  // one classic cycle, held until ack is sampled
  task wb(input logic we, input logic [7:0] ad, input logic [31:0] wd,
    output logic [31:0] rd);
    @(posedge ref_clk);
    wb_cyc <= 1'h1;
    wb_stb <= 1'h1;
    wb_we <= we;
    wb_adr <= ad;
    wb_dat_w <= wd;
    do @(posedge ref_clk); while (wb_ack !== 1'h1);
    rd = wb_dat_r;
    wb_cyc <= 1'h0;
    wb_stb <= 1'h0;
  endtask : wb
  task cfg(input logic [1:0] p, input logic [1:0] dw);
    wb(1'h1, vwi_pkg::REG_CTRL0, {28'h000_0000, dw, p}, q);
    wb(1'h1, vwi_pkg::REG_CTRL1, {28'h000_0000, dw, p}, q);
    phys0 = p;
    phys1 = p;
  endtask : cfg
  // request held until taken, then wait for the answer
  task rq(input logic wr, input logic pg, input logic [23:0] ad,
    input logic [31:0] wd, output logic [31:0] rd);
    @(posedge ref_clk);
    beats = 0;
    req_valid <= 1'h1;
    req_write <= wr;
    req_prog <= pg;
    req_addr <= ad;
    req_wdata <= wd;
    do @(posedge ref_clk); while (req_ready !== 1'h1);
    req_valid <= 1'h0;
    do @(posedge ref_clk); while (resp_valid !== 1'h1);
    rd = resp_rdata;
  endtask : rq
  function automatic int nb(input logic [1:0] e);
    nb = (e == 2'h0) ? 1 : (e == 2'h1) ? 2 : 4;
  endfunction : nb
  initial
  begin
    repeat (8) @(posedge ref_clk);
    q = 32'({s0_lane0_enable_n, s1_lane0_enable_n, io_strobe_n});
    chk(q, 32'h0000_0007);
    rst_n <= 1'h1;
    wb(1'h0, vwi_pkg::REG_CTRL1, 32'h0000_0000, q);
    chk(q, 32'h0000_000a);
    wb(1'h1, vwi_pkg::REG_STATUS, 32'hffff_ffff, q);
    wb(1'h0, vwi_pkg::REG_STATUS, 32'h0000_0000, q);
    chk(q, 32'h0000_0000);
    wb(1'h0, 8'h0c, 32'h0000_0000, q);
    chk(q, 32'h0000_0000);
    // eight width pairs (all but 16/16), reconfigured on the fly, both sets in turn
    for (int i = 0; i < 8; i++)
    begin
      r = tab[i];
      cfg(r[15:14], r[13:12]);
      tgt = {1'h0, i[0]};
      a = {i[0], 19'h0_0000, r[11:8]};
      d = 32'hc3a5_5a3c ^ 32'(i);
      eb = nb(r[13:12]) > nb(r[15:14]) ? nb(r[13:12]) / nb(r[15:14]) : 1;
      rq(1'h1, 1'h0, a, d, q);
      chk(32'(beats), 32'(eb));
      q = 32'(r[7:4] & r[3:0]);
      chk(32'(pins1 & r[3:0]), q);
      rq(1'h0, 1'h0, a, 32'h0000_0000, q);
      d = d & ((r[13:12] == 2'h0) ? 32'h0000_00ff :
        (r[13:12] == 2'h1) ? 32'h0000_ffff : 32'hffff_ffff);
      chk(q, d);
    end
    // io area ignores the narrow set configuration
    tgt = 2'h2;
    d = 32'h1234_5678;
    rq(1'h1, 1'h0, 24'h81_0010, d, q);
    chk(32'(beats), 32'h0000_0001);
    rq(1'h0, 1'h0, 24'h81_0010, 32'h0000_0000, q);
    chk(q, d);
    // program halves from a 16-bit area, even with set at 8 bits
    tgt = 2'h0;
    cfg(2'h1, 2'h2);
    d = 32'h9e37_79b9;
    rq(1'h1, 1'h0, 24'h00_0004, d, q);
    cfg(2'h0, 2'h0);
    phys0 = 2'h1;
    program_width_select <= 1'h1;
    repeat (6) @(posedge ref_clk);
    wb(1'h0, vwi_pkg::REG_STATUS, 32'h0000_0000, q);
    chk(q, 32'h0000_0002);
    rq(1'h0, 1'h1, 24'h00_0004, 32'h0000_0000, q);
    chk(q, d);
    chk(32'(beats), 32'h0000_0002);
    // pin low: one full word per fetch
    program_width_select <= 1'h0;
    // reserved width code must behave as a full 32-bit word
    cfg(2'h3, 2'h3);
    repeat (6) @(posedge ref_clk);
    d = 32'h7f4a_7c15;
    rq(1'h1, 1'h0, 24'h00_0006, d, q);
    rq(1'h0, 1'h1, 24'h00_0006, 32'h0000_0000, q);
    chk(q, d);
    chk(32'(beats), 32'h0000_0001);
    report_and_stop();
  end
endmodule : test_variable_width_ext_mem_interface
bind vwi_ext_mem_if vwi_ext_mem_if_chk #(
  .MEM_CYC(MEM_CYC),
  .IO_CYC(IO_CYC)
) u_chk (.*);
`default_nettype wire
